// ### core/fpptm_pkg.sv
/*
  Constants, field layouts and carrier types for the frame port
  performance and test monitor.
  Assumes a single 25 MHz system clock and a plain register port.
*/
package fpptm_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;          // System clock period
  localparam int unsigned SECOND_NS = 1000000000;      // One second in ns
  localparam int unsigned SEC_CYCLES = SECOND_NS / CLK_PERIOD_NS; // Cycles per second
  localparam int unsigned HOUR_S = 3600;               // Hourly interval in seconds
  localparam int unsigned QUARTER_S = 900;             // Drop counting period in seconds

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned HIST_DEPTH = 24;             // Past hourly slots kept
  localparam int unsigned PAGE_ROWS = 12;              // History rows per page
  localparam int unsigned ADDR_W = 10;                 // Register address width
  localparam int unsigned DATA_W = 32;                 // Register data width
  localparam int unsigned NUM_CNT = 6;                 // Counters per interval
  localparam int unsigned NUM_TST = 6;                 // Test result counters

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [9:0] OFS_CTRL = 10'h000;           // Commands and page select
  localparam logic [9:0] OFS_STAT = 10'h004;           // Sync status as of the last refresh
  localparam logic [9:0] OFS_SECS = 10'h008;           // Seconds into the hour as of the last refresh
  localparam logic [9:0] OFS_TEST = 10'h010;           // First of six test words
  localparam logic [9:0] OFS_PERF = 10'h200;           // Performance table base
  localparam int unsigned ROW_TOTAL = 13;              // Table row holding totals
  localparam int unsigned COL_STATUS = 6;              // Table column holding codes

  // ----------------------------------------------------------------
  // Control word bits
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_REFRESH = 0;            // Pulse: take snapshot
  localparam int unsigned CTRL_PAGE = 1;               // Level: 0 first page, 1 second
  localparam int unsigned CTRL_INSERT = 2;             // Pulse: insert one error
  localparam int unsigned CTRL_CLEAR = 3;              // Pulse: clear test results
  localparam int unsigned CTRL_RUN = 4;                // Level: test running

  // ----------------------------------------------------------------
  // Counter columns and test word indices
  // ----------------------------------------------------------------
  localparam int unsigned COL_FRM_RX = 0;
  localparam int unsigned COL_FRM_TX = 1;
  localparam int unsigned COL_OCT_RX = 2;
  localparam int unsigned COL_OCT_TX = 3;
  localparam int unsigned COL_DRP_RX = 4;
  localparam int unsigned COL_DRP_TX = 5;
  localparam int unsigned TST_GEN = 0;                 // generated_frame_amount
  localparam int unsigned TST_RX = 1;                  // test_received_amount
  localparam int unsigned TST_EF = 2;                  // errored_frame_count
  localparam int unsigned TST_ES = 3;                  // errored_second_count
  localparam int unsigned TST_TEST_ELAPSED_SECONDS = 4;                // test_elapsed_seconds
  localparam int unsigned TST_IEC = 5;                 // inserted error count

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef logic [NUM_CNT-1:0][DATA_W-1:0] fpptm_cnt_t;
  typedef logic [NUM_TST-1:0][DATA_W-1:0] fpptm_tst_t;

  typedef struct packed {
    logic dte_down;                                    // T: terminal side down
    logic loopback;                                    // L: loopback active
    logic standby;                                     // S: port in standby
  } fpptm_cond_s;

  typedef struct packed {
    fpptm_cnt_t cnt;
    fpptm_cond_s cond;
  } fpptm_row_s;

endpackage

// ### core/fpptm_monitor.sv
/*
  Frame port performance and test monitor: hourly statistics with a
  24 hour history and totals, plus the test result counters.
  Software reads frozen snapshots taken by a refresh write,
  so a page of many words belongs to one instant.
  Assumes all event and condition inputs come from logic on sys_clk,
  each event a one-cycle pulse that counts once per edge,
  and a register master that never needs a wait state.
  Assumes sys_clk never stops: every interval boundary
  is a plain division of that clock.
*/
`timescale 1ns/1ns
module fpptm_monitor
  import fpptm_pkg::*;
#(
  parameter int unsigned SEC_CNT = SEC_CYCLES        // Cycles per second tick
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic rx_frame,
  input wire logic tx_frame,
  input wire logic rx_octet,
  input wire logic tx_octet,
  input wire logic rx_drop,
  input wire logic tx_drop,
  input wire fpptm_cond_s port_cond,
  input wire logic test_gen_frame,
  input wire logic test_rx_frame,
  input wire logic test_frame_err,
  input wire logic test_lock,
  output logic error_insert_command
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  // Time base
  logic [31:0] tick_cnt_q;                  // Cycles within the second
  logic sec_tick_q;                         // One-cycle second pulse
  logic [11:0] hour_sec_q;                  // Seconds into current hour
  logic [9:0] quarter_sec_q;                // Seconds into current quarter
  logic hour_end;                           // Last cycle of the hour
  logic quarter_end;                        // Last cycle of a quarter
  logic [NUM_CNT-1:0] ev;                   // Counter events this cycle
  // Statistics: live, history, snapshot
  fpptm_row_s cur_q;                        // current_interval figures
  fpptm_row_s hist_q [HIST_DEPTH];          // Past hours, 0 is newest
  fpptm_cnt_t tot_q;                        // Running 24 hour totals
  fpptm_row_s snap_q [HIST_DEPTH+1];        // Snapshot, 0 is current
  fpptm_row_s snap_tot_q;                   // Snapshot totals
  logic [11:0] snap_sec_q;                  // Snapshot seconds
  // Test section
  fpptm_tst_t tst_q;                        // Live test results
  fpptm_tst_t tst_snap_q;                   // Presented test results
  logic sync_q;                             // Live test sync flag
  logic sync_snap_q;                        // Presented sync flag
  logic sec_err_q;                          // Error seen this second
  // Control state written by software
  logic run_q;                              // Test running
  logic page_q;                             // history_page_second when set
  logic refresh;                            // Snapshot command
  logic insert;                             // Error insert command
  logic clear;                              // Test clear command
  // Read path
  fpptm_cond_s tot_cond;                    // Codes seen in any past hour
  logic [DATA_W-1:0] rd_d;                  // Read data for next cycle
  logic [3:0] row;                          // Table row of a read
  logic [2:0] col;                          // Table column of a read
  logic [4:0] idx;                          // Snapshot slot of a read

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // Pulses act in the write cycle only; none is
  // stored, so no later write repeats an old one
  assign refresh = reg_wr && reg_addr == OFS_CTRL && reg_wdata[CTRL_REFRESH];
  assign insert = reg_wr && reg_addr == OFS_CTRL && reg_wdata[CTRL_INSERT];
  assign clear = reg_wr && reg_addr == OFS_CTRL && reg_wdata[CTRL_CLEAR];

  // Level controls keep their value until rewritten
  // Every control write sets both, pulses or not
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      page_q <= 1'b0;
      run_q <= 1'b0;
    end else if (reg_wr && reg_addr == OFS_CTRL) begin
      page_q <= reg_wdata[CTRL_PAGE];
      run_q <= reg_wdata[CTRL_RUN];
    end
  end

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  // Divide the system clock down to a one-second pulse
  // SEC_CNT lets a bench shorten the second; hour
  // and quarter stay counted in ticks
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_q <= 32'h0000_0000;
      sec_tick_q <= 1'b0;
    end else if (tick_cnt_q == 32'(SEC_CNT - 1)) begin
      tick_cnt_q <= 32'h0000_0000;
      sec_tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
      sec_tick_q <= 1'b0;
    end
  end

  // Boundaries fall on the tick closing the last second
  assign hour_end = sec_tick_q && hour_sec_q == 12'(HOUR_S - 1);
  assign quarter_end = sec_tick_q && quarter_sec_q == 10'(QUARTER_S - 1);

  // Seconds since the last hour boundary, and within the quarter
  // One tick drives both, so the boundaries line up
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      hour_sec_q <= 12'h000;
      quarter_sec_q <= 10'h000;
    end else if (sec_tick_q) begin
      hour_sec_q <= hour_end ? 12'h000 : hour_sec_q + 12'h001;
      quarter_sec_q <= quarter_end ? 10'h000 : quarter_sec_q + 10'h001;
    end
  end

  // ----------------------------------------------------------------
  // Current interval counters
  // ----------------------------------------------------------------
  // Event pulses in the column order of the table
  always_comb begin
    ev = '0;
    ev[COL_FRM_RX] = rx_frame;
    ev[COL_FRM_TX] = tx_frame;
    ev[COL_OCT_RX] = rx_octet;
    ev[COL_OCT_TX] = tx_octet;
    ev[COL_DRP_RX] = rx_drop;
    ev[COL_DRP_TX] = tx_drop;
  end

  // Counters are 32 bits and wrap with no flag;
  // software must read often to see each wrap
  // Drops restart each quarter, so history keeps
  // only the last quarter of the hour
  // An event in the boundary cycle starts the new interval, so none is lost
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CNT; i++) begin
        if (hour_end) begin
          cur_q.cnt[i] <= 32'(ev[i]);
        end else if (quarter_end && (i == COL_DRP_RX || i == COL_DRP_TX)) begin
          cur_q.cnt[i] <= 32'(ev[i]);
        end else begin
          cur_q.cnt[i] <= cur_q.cnt[i] + 32'(ev[i]);
        end
      end
      // Codes are sticky over the interval so a brief outage still shows
      cur_q.cond <= hour_end ? port_cond : (cur_q.cond | port_cond);
    end
  end

  // ----------------------------------------------------------------
  // History and totals
  // ----------------------------------------------------------------
  // Oldest slot falls off; totals add the closing hour, drop the oldest
  // Add and subtract instead of summing 24 slots:
  // one register word per counter saves a wide adder tree
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < HIST_DEPTH; i++) begin
        hist_q[i] <= '0;
      end
      tot_q <= '0;
    end else if (hour_end) begin
      hist_q[0] <= cur_q;
      for (int i = 1; i < HIST_DEPTH; i++) begin
        hist_q[i] <= hist_q[i-1];
      end
      for (int i = 0; i < NUM_CNT; i++) begin
        tot_q[i] <= tot_q[i] + cur_q.cnt[i] - hist_q[HIST_DEPTH-1].cnt[i];
      end
    end
  end

  // Total row code: any condition seen in the past 24 hours
  // The code leaves the total with its oldest slot
  always_comb begin
    tot_cond = '0;
    for (int i = 0; i < HIST_DEPTH; i++) begin
      tot_cond = tot_cond | hist_q[i].cond;
    end
  end

  // ----------------------------------------------------------------
  // Snapshot
  // ----------------------------------------------------------------
  // Software sees a frozen copy; costs a second register set, but reads
  // across many words then stay consistent with one another
  // Events in the refresh cycle go to the next one
  // Reset leaves an all-zero snapshot
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i <= HIST_DEPTH; i++) begin
        snap_q[i] <= '0;
      end
      snap_tot_q <= '0;
      snap_sec_q <= 12'h000;
    end else if (refresh) begin
      snap_q[0] <= cur_q;
      for (int i = 0; i < HIST_DEPTH; i++) begin
        snap_q[i+1] <= hist_q[i];
      end
      snap_tot_q.cnt <= tot_q;
      snap_tot_q.cond <= tot_cond;
      snap_sec_q <= hour_sec_q;
    end
  end

  // ----------------------------------------------------------------
  // Test section
  // ----------------------------------------------------------------
  // Sync follows the receiver lock while the test runs
  // Lock is shown only after the next refresh
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_q <= 1'b0;
    end else begin
      sync_q <= run_q && test_lock;
    end
  end

  // Error seen in the running second. An error in the
  // tick cycle counts in the closing second directly;
  // setting the flag then would count it twice
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sec_err_q <= 1'b0;
    end else if (sec_tick_q || clear || !run_q) begin
      sec_err_q <= 1'b0;
    end else if (test_frame_err) begin
      sec_err_q <= 1'b1;
    end
  end

  // Live test results; clear wins as it restarts the measurement
  // Nothing counts while stopped, so results
  // stay frozen between runs
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tst_q <= '0;
    end else if (clear) begin
      tst_q <= '0;
    end else if (run_q) begin
      if (test_gen_frame) begin
        tst_q[TST_GEN] <= tst_q[TST_GEN] + 32'h0000_0001;
      end
      if (test_rx_frame) begin
        tst_q[TST_RX] <= tst_q[TST_RX] + 32'h0000_0001;
      end
      if (test_frame_err) begin
        tst_q[TST_EF] <= tst_q[TST_EF] + 32'h0000_0001;
      end
      if (sec_tick_q && (sec_err_q || test_frame_err)) begin
        tst_q[TST_ES] <= tst_q[TST_ES] + 32'h0000_0001;
      end
      if (sec_tick_q) begin
        tst_q[TST_TEST_ELAPSED_SECONDS] <= tst_q[TST_TEST_ELAPSED_SECONDS] + 32'h0000_0001;
      end
      if (insert) begin
        tst_q[TST_IEC] <= tst_q[TST_IEC] + 32'h0000_0001;
      end
    end
  end

  // One-cycle pulse to the pattern generator
  // Ignored while stopped: no stray line error
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      error_insert_command <= 1'b0;
    end else begin
      error_insert_command <= insert && run_q;
    end
  end

  // Presented test results follow refresh; clear empties them at once
  // Clear beats a refresh in the same word
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tst_snap_q <= '0;
      sync_snap_q <= 1'b0;
    end else if (clear) begin
      tst_snap_q <= '0;
      sync_snap_q <= 1'b0;
    end else if (refresh) begin
      tst_snap_q <= tst_q;
      sync_snap_q <= sync_q;
    end
  end

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  // Table word: base + row * 0x20 + column * 4
  // Row 0 current, 1 to 12 paged history, 13 totals
  // Column 6 holds codes T, L, S in bits 2 to 0
  assign row = reg_addr[8:5];
  assign col = reg_addr[4:2];
  // Page select maps table rows 1..12 onto slots 1..12 or 13..24
  assign idx = (page_q && row != 4'h0) ? 5'(row) + 5'(PAGE_ROWS) : 5'(row);

  // Unmapped words and unused columns read zero
  // Address bits 1 and 0 are ignored in the table and test words only
  always_comb begin
    rd_d = '0;
    if (reg_addr[9]) begin
      if (row == 4'(ROW_TOTAL)) begin
        rd_d = (col == 3'(COL_STATUS)) ? 32'(snap_tot_q.cond) :
               (col < 3'(COL_STATUS)) ? snap_tot_q.cnt[col] : '0;
      end else if (row < 4'(ROW_TOTAL)) begin
        rd_d = (col == 3'(COL_STATUS)) ? 32'(snap_q[idx].cond) :
               (col < 3'(COL_STATUS)) ? snap_q[idx].cnt[col] : '0;
      end
    end else if (reg_addr == OFS_CTRL) begin
      rd_d[CTRL_PAGE] = page_q;
      rd_d[CTRL_RUN] = run_q;
    end else if (reg_addr == OFS_STAT) begin
      rd_d[0] = sync_snap_q;
    end else if (reg_addr == OFS_SECS) begin
      rd_d = 32'(snap_sec_q);
    end else if (reg_addr[9:2] >= OFS_TEST[9:2] &&
                 reg_addr[9:2] < OFS_TEST[9:2] + 8'(NUM_TST)) begin
      rd_d = tst_snap_q[3'(reg_addr[9:2] - OFS_TEST[9:2])];
    end
  end

  // Read data stand only in the cycle after the strobe; else zero
  // Zero when idle keeps stale words off the bus
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_d : '0;
    end
  end

endmodule

// ### dv/fpptm_chk.sv
/*
  Checker for the monitor: register port replies and the insert pulse.
  Assumes it is bound onto fpptm_monitor and sees only its ports.
*/
`timescale 1ns/1ns
module fpptm_chk
  import fpptm_pkg::*;
#(
  parameter int unsigned SEC_CNT = SEC_CYCLES // Kept in step with the design
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic error_insert_command
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic ctl_wr, ins_req, st_rd_q, st_ok_q, run_seen_q;
  logic [1:0] pg_run;
  logic [DATA_W-1:0] st_q; // Last presented sync word
  assign ctl_wr = reg_wr && reg_addr == OFS_CTRL;
  // Insert acts only while a run written earlier stands
  assign ins_req = ctl_wr && reg_wdata[CTRL_INSERT] && run_seen_q;
  assign pg_run = {reg_wdata[CTRL_RUN], reg_wdata[CTRL_PAGE]};
  // Run level as last written over the port
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      run_seen_q <= 1'b0;
    end else if (ctl_wr) begin
      run_seen_q <= reg_wdata[CTRL_RUN];
    end
  end
  // Remember the sync word; any control write may change it, so forget it then
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_rd_q <= 1'b0;
      st_ok_q <= 1'b0;
      st_q <= '0;
    end else begin
      st_rd_q <= reg_rd && reg_addr == OFS_STAT;
      if (ctl_wr) begin
        st_ok_q <= 1'b0;
      end else if (st_rd_q) begin
        st_ok_q <= 1'b1;
        st_q <= reg_rdata;
      end
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data not zero outside a reply");
  a_refresh_reads0: assert property (reg_rd && reg_addr == OFS_CTRL |=> !reg_rdata[CTRL_REFRESH])
    else $error("refresh bit read back high");
  a_sync_held: assert property (st_rd_q && st_ok_q |-> reg_rdata == st_q)
    else $error("sync word changed without refresh");
  a_stat_bits: assert property (reg_rd && reg_addr == OFS_STAT |=> reg_rdata[DATA_W-1:1] == '0)
    else $error("status word has stray bits");
  a_secs_range: assert property (reg_rd && reg_addr == OFS_SECS |=> reg_rdata < HOUR_S)
    else $error("seconds beyond one hour");
  a_unmapped_zero: assert property (reg_rd && reg_addr inside {10'h00c, [10'h028:10'h1fc]} |=> reg_rdata == '0)
    else $error("unmapped address read nonzero");
  a_status_code: assert property (reg_rd && reg_addr >= OFS_PERF && reg_addr[4:2] == 3'h6
    |=> reg_rdata[DATA_W-1:3] == '0)
    else $error("status code has stray bits");
  a_page_back: assert property (ctl_wr ##1 !reg_wr ##1 (reg_rd && reg_addr == OFS_CTRL)
    |=> {reg_rdata[CTRL_RUN], reg_rdata[CTRL_PAGE]} == $past(pg_run, 3))
    else $error("page or run not read back");
  a_insert_go: assert property (ins_req |=> error_insert_command)
    else $error("insert command not issued");
  a_insert_why: assert property (error_insert_command |-> $past(ins_req))
    else $error("insert pulse without a running insert write");
  c_insert: cover property (ins_req);
  c_sync_reread: cover property (st_rd_q && st_ok_q);
  c_secs_read: cover property (reg_rd && reg_addr == OFS_SECS);
endmodule

bind fpptm_monitor fpptm_chk #(.SEC_CNT(SEC_CNT)) u_chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .error_insert_command(error_insert_command));

// ### dv/fpptm_sw_model.sv
/*
  Management software model: one register access at a time.
  Assumes the bench calls wr and rd by hierarchical reference.
*/
`timescale 1ns/1ns
module fpptm_sw_model
  import fpptm_pkg::*;
(
  input wire logic sys_clk,
  output logic [ADDR_W-1:0] reg_addr,
  output logic [DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata
);
  // Bus idle at time zero
  initial begin
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Refresh, insert and clear are all control writes from software
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a; // Released lines do not keep the last value
    reg_wdata <= ~d;
  endtask
  // Reply is taken mid-cycle, in the one cycle that it stands
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] q);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(negedge sys_clk);
    q = reg_rdata;
  endtask
endmodule

// ### dv/fpptm_monitor_tb.sv
/*
  Bench for the monitor: line events, hour history, test counters.
  Assumes the software model and the checker are compiled first.
*/
`timescale 1ns/1ns
module fpptm_monitor_tb
  import fpptm_pkg::*;
;
  localparam int S = 2; // Shortened second keeps three hours short
  logic sys_clk, reset_n, wr, rd, ins, lock;
  logic [8:0] stim; // Test err,rx,gen then drops, octets, frames
  fpptm_cond_s cond;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, v, s0;
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  int cnt [6] = '{3, 4, 5, 6, 1, 2};
  int te [6] = '{3, 4, 2, 2, 20, 1};
  fpptm_sw_model sw (.sys_clk(sys_clk), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdata));
  fpptm_monitor #(.SEC_CNT(S)) uut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .rx_frame(stim[0]),
    .tx_frame(stim[1]), .rx_octet(stim[2]), .tx_octet(stim[3]), .rx_drop(stim[4]),
    .tx_drop(stim[5]), .port_cond(cond), .test_gen_frame(stim[6]), .test_rx_frame(stim[7]),
    .test_frame_err(stim[8]), .test_lock(lock), .error_insert_command(ins));
  // ----------------------------------------------------------------
  // Clock, cycle count and watchdog
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= cyc + 1;
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    test_done();
  end
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    sw.rd(a, v);
    chk($sformatf("reg %h", a), v, exp);
  endtask
  function automatic logic [ADDR_W-1:0] pa(input int r, input int c);
    return ADDR_W'(OFS_PERF + r * 32 + c * 4);
  endfunction
  // One table row: k times the event counts, drops scaled by dk
  task automatic row(input int r, input int k, input int dk, input logic [2:0] st);
    for (int c = 0; c < 6; c++) begin
      rdc(pa(r, c), 32'((c < 4 ? k : dk) * cnt[c]));
    end
    rdc(pa(r, 6), {29'h0, st});
  endtask
  // One-cycle pulses on one event line, back to back
  task automatic burst(input int b, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      stim <= 9'h1 << b;
    end
    @(posedge sys_clk);
    stim <= '0;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    stim = '0;
    cond = '0;
    lock = 1'b0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    sw.wr(OFS_CTRL, 32'h1);
    rdc(OFS_CTRL, 32'h0);
    rdc(OFS_STAT, 32'h0);
    rdc(10'h100, 32'h0);
    @(posedge sys_clk);
    cond <= 3'h5;
    for (int i = 0; i < 6; i++) begin
      burst(i, cnt[i]);
    end
    rdc(pa(0, 0), 32'h0);
    sw.wr(OFS_CTRL, 32'h1);
    row(0, 1, 1, 3'h5);
    // Two refreshes exactly ten seconds apart
    sw.wr(OFS_CTRL, 32'h1);
    fork
      repeat (10 * S - 2) @(posedge sys_clk);
      sw.rd(OFS_SECS, s0);
    join
    sw.wr(OFS_CTRL, 32'h1);
    sw.rd(OFS_SECS, v);
    chk("seconds step", v - s0, 32'ha);
    // Test run of exactly twenty seconds
    sw.wr(OFS_CTRL, 32'h10);
    fork
      repeat (20 * S - 2) @(posedge sys_clk);
      begin
        burst(6, 3);
        burst(7, 4);
        burst(8, 1);
        sw.wr(OFS_CTRL, 32'h11);
        rdc(OFS_STAT, 32'h0);
        @(posedge sys_clk);
        lock <= 1'b1;
        @(posedge sys_clk);
        burst(8, 1);
        rdc(OFS_STAT, 32'h0);
        sw.wr(OFS_CTRL, 32'h11);
        rdc(OFS_STAT, 32'h1);
        sw.wr(OFS_CTRL, 32'h14);
        @(negedge sys_clk);
        chk("insert pulse", {31'h0, ins}, 32'h1);
      end
    join
    sw.wr(OFS_CTRL, 32'h0); // Stop the test
    sw.wr(OFS_CTRL, 32'h4); // Insert ignored while stopped
    sw.wr(OFS_CTRL, 32'h1);
    for (int i = 0; i < 6; i++) begin
      rdc(ADDR_W'(OFS_TEST + 4 * i), 32'(te[i]));
    end
    sw.wr(OFS_CTRL, 32'h8);
    for (int i = 0; i < 6; i++) begin
      rdc(ADDR_W'(OFS_TEST + 4 * i), 32'h0);
    end
    // Second hour: first hour moves to slot one and the total
    while (cyc < 7300) @(posedge sys_clk);
    cond <= 3'h2;
    sw.wr(OFS_CTRL, 32'h1);
    row(0, 0, 0, 3'h7);
    row(1, 1, 0, 3'h5);
    row(13, 1, 0, 3'h5);
    sw.wr(OFS_CTRL, 32'h3);
    rdc(OFS_CTRL, 32'h2);
    row(1, 0, 0, 3'h0);
    sw.wr(OFS_CTRL, 32'h1);
    for (int i = 0; i < 4; i++) begin
      burst(i, cnt[i]);
    end
    sw.wr(OFS_CTRL, 32'h1);
    rdc(pa(0, 0), 32'(cnt[0]));
    rdc(pa(13, 0), 32'(cnt[0]));
    // Third hour: slots age by one, total sums both hours
    while (cyc < 14500) @(posedge sys_clk);
    sw.wr(OFS_CTRL, 32'h1);
    row(1, 1, 0, 3'h7);
    row(2, 1, 0, 3'h5);
    row(13, 2, 0, 3'h7);
    test_done();
  end
endmodule
